// >>> arr_pkg.sv
// package: offsets, reset values, field layouts and encodings of the result bank
//
// Overview of operation
// (RULE_01) bit 7 of battery result shows thermal regulation
// (RULE_02) battery code bits 6..0, offset plus step
// (RULE_03) battery code reads zero after reset
// (RULE_04) system code, same offset and step as battery
// (RULE_05) bit 7 of system, thermistor, current reads 0
// (RULE_06) thermistor code as ratio of regulator rail
// (RULE_07) bit 7 of input result shows supply present
// (RULE_08) input supply code bits 6..0, fixed step
// (RULE_09) charge current code, zero offset, binary weights
// (RULE_10) current code forced zero below short threshold
// (RULE_11) all result bits read-only, writes ignored
// (RULE_12) each code updates whole on conversion done
package arr_pkg;
   localparam int unsigned CODE_W      = 7;        // width of one converter code
   localparam int unsigned ADDR_W      = 8;        // register address width
   localparam int unsigned DATA_W      = 8;        // register data width
   localparam int unsigned FLAG_BIT    = 7;        // position of the status flag bit
   localparam logic [7:0] OFS_BATT     = 8'h0e;    // battery voltage result
   localparam logic [7:0] OFS_SYS      = 8'h0f;    // system voltage result
   localparam logic [7:0] OFS_THERM    = 8'h10;    // thermistor ratio result
   localparam logic [7:0] OFS_INPUT    = 8'h11;    // input supply voltage result
   localparam logic [7:0] OFS_CURR     = 8'h12;    // charge current result
   localparam logic [6:0] RST_CODE     = 7'h00;    // code after reset (offset value)
   localparam logic [7:0] RD_UNMAPPED  = 8'h00;    // answer outside this bank
   localparam logic [7:0] RST_RDATA    = 8'h00;    // read data after reset
   // scale figures kept for reference by software models
   localparam int unsigned VOLT_OFS_MV = 2304;     // battery/system offset, mV
   localparam int unsigned VOLT_STEP_MV = 20;      // battery/system step, mV
   localparam int unsigned VIN_OFS_MV  = 2600;     // input supply offset, mV
   localparam int unsigned VIN_STEP_MV = 100;      // input supply step, mV
   localparam int unsigned CUR_STEP_MA = 50;       // charge current step, mA
   localparam int unsigned TS_OFS_PPK  = 21000;    // thermistor offset, 1/1000 %
   localparam int unsigned TS_STEP_PPK = 465;      // thermistor step, 1/1000 %

   // channel selector for a completed conversion
   typedef enum logic [2:0] {
      CH_BATT  = 3'b000,
      CH_SYS   = 3'b001,
      CH_THERM = 3'b010,
      CH_INPUT = 3'b011,
      CH_CURR  = 3'b100
   } arr_chan_e;

   // one finished conversion from the converter
   typedef struct packed {
      logic       done;    // one-cycle strobe
      arr_chan_e  chan;    // which channel finished
      logic [6:0] code;    // new 7-bit code
   } arr_conv_s;

   // register read request
   typedef struct packed {
      logic       rd;      // read strobe
      logic [7:0] addr;    // register offset
   } arr_rd_s;
endpackage : arr_pkg

// >>> arr_code_reg.sv
// holds one converter code, replaced whole on a completed conversion
`timescale 1ns/1ps
module arr_code_reg #(
   parameter int unsigned W = 7              // code width
) (
   input  wire logic         i_mclk,         // system clock
   input  wire logic         i_reset_n,      // async reset, active low
   input  wire logic         i_load,         // conversion done for this channel
   input  wire logic [W-1:0] i_code,         // new code
   output logic      [W-1:0] o_code          // held code
);
   logic [W-1:0] code_ff;                    // stored code
   logic [W-1:0] nxt_code;                   // next stored code

   // whole-word replace; no partial update is possible
   always_comb begin
      nxt_code = code_ff;
      if (i_load) begin
         nxt_code = i_code;                  // [RULE_12]
      end
   end

   // register; reset to the offset code
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         code_ff <= W'(arr_pkg::RST_CODE);   // [RULE_03]
      end else begin
         code_ff <= nxt_code;
      end
   end

   assign o_code = code_ff;
endmodule : arr_code_reg

// >>> arr_sync2.sv
// two-flop synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
module arr_sync2 (
   input  wire logic i_mclk,      // system clock
   input  wire logic i_reset_n,   // async reset, active low
   input  wire logic i_async,     // asynchronous level
   output logic      o_sync       // synchronised level
);
   logic meta_ff;                 // first stage, read only by second
   logic sync_ff;                 // second stage
   logic nxt_meta;                // next first stage
   logic nxt_sync;                // next second stage

   // shift chain
   always_comb begin
      nxt_meta = i_async;
      nxt_sync = meta_ff;
   end

   // register both stages
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
      end else begin
         meta_ff <= nxt_meta;
         sync_ff <= nxt_sync;
      end
   end

   assign o_sync = sync_ff;
endmodule : arr_sync2

// >>> arr_result_bank.sv
// read-only bank of converter result registers with status flags
`timescale 1ns/1ps
module arr_result_bank (
   input  wire logic              i_mclk,              // 100 MHz system clock
   input  wire logic              i_reset_n,           // async reset, active low
   input  wire arr_pkg::arr_conv_s i_conv,             // finished conversion, same domain
   input  wire logic              i_thermal_reg_flag,  // thermal regulation, async level
   input  wire logic              i_input_present_flag,// supply attached, async level
   input  wire logic              i_batt_below_short,  // battery under short threshold
   input  wire arr_pkg::arr_rd_s  i_rd,                // read request from serial engine
   input  wire logic              i_wr,                // write strobe, ignored here
   input  wire logic [7:0]        i_wdata,             // write data, ignored here
   output logic [7:0]             o_rdata,             // read data, registered
   output logic                   o_rvalid,            // read data valid pulse
   output logic                   o_hit                // address fell in this bank
);
   localparam int unsigned NCH = 5;                    // number of result channels

   logic [6:0]       code_w [NCH];                     // held codes per channel
   logic [NCH-1:0]   load_w;                           // load strobe per channel
   logic [6:0]       curr_in;                          // current code after forcing
   logic             therm_s;                          // synchronised thermal flag
   logic             vin_s;                            // synchronised present flag
   logic             short_s;                          // synchronised short level
   logic [7:0]       rdata_ff;                         // read data register
   logic [7:0]       nxt_rdata;                        // next read data
   logic             rvalid_ff;                        // read valid register
   logic             nxt_rvalid;                       // next read valid
   logic             hit_ff;                           // address hit register
   logic             nxt_hit;                          // next hit
   logic             unused_wr;                        // writes are dropped

   // writes land nowhere; the bank has no writable bit
   assign unused_wr = i_wr ^ (^i_wdata);               // [RULE_11]

   // status levels come from analog comparators, so resynchronise
   arr_sync2 u_sync_therm (
      .i_mclk    (i_mclk),
      .i_reset_n (i_reset_n),
      .i_async   (i_thermal_reg_flag),
      .o_sync    (therm_s)
   );
   arr_sync2 u_sync_vin (
      .i_mclk    (i_mclk),
      .i_reset_n (i_reset_n),
      .i_async   (i_input_present_flag),
      .o_sync    (vin_s)
   );
   arr_sync2 u_sync_short (
      .i_mclk    (i_mclk),
      .i_reset_n (i_reset_n),
      .i_async   (i_batt_below_short),
      .o_sync    (short_s)
   );

   // decode which channel a conversion belongs to
   function automatic logic [NCH-1:0] chan_dec(input arr_pkg::arr_chan_e c, input logic d);
      chan_dec = '0;
      if (d) begin
         case (c)
            arr_pkg::CH_BATT:  chan_dec = 5'h01;
            arr_pkg::CH_SYS:   chan_dec = 5'h02;
            arr_pkg::CH_THERM: chan_dec = 5'h04;
            arr_pkg::CH_INPUT: chan_dec = 5'h08;
            arr_pkg::CH_CURR:  chan_dec = 5'h10;
            default:           chan_dec = '0;   // unknown channel dropped
         endcase
      end
   endfunction : chan_dec

   assign load_w = chan_dec(i_conv.chan, i_conv.done);

   // a short battery gives meaningless current, so store zero
   assign curr_in = short_s ? 7'h00 : i_conv.code;     // [RULE_10]

   // one whole-word holder per channel
   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_ch
         arr_code_reg #(
            .W (arr_pkg::CODE_W)
         ) u_code (
            .i_mclk    (i_mclk),
            .i_reset_n (i_reset_n),
            .i_load    (load_w[g]),
            .i_code    ((g == NCH-1) ? curr_in : i_conv.code),  // [RULE_12]
            .o_code    (code_w[g])
         );
      end
   endgenerate

   // read mux; codes in 6..0, flags or zero in bit 7
   always_comb begin
      nxt_rdata  = arr_pkg::RD_UNMAPPED;
      nxt_hit    = 1'b0;
      nxt_rvalid = i_rd.rd;
      if (i_rd.rd) begin
         nxt_hit = 1'b1;
         case (i_rd.addr)
            arr_pkg::OFS_BATT:
               nxt_rdata = {therm_s, code_w[0]};                      // [RULE_01] [RULE_02]
            arr_pkg::OFS_SYS:
               nxt_rdata = {1'b0, code_w[1]};                         // [RULE_04] [RULE_05]
            arr_pkg::OFS_THERM:
               nxt_rdata = {1'b0, code_w[2]};                         // [RULE_06] [RULE_05]
            arr_pkg::OFS_INPUT:
               nxt_rdata = {vin_s, code_w[3]};                        // [RULE_07] [RULE_08]
            arr_pkg::OFS_CURR:
               nxt_rdata = {1'b0, code_w[4] & {7{~short_s}}};         // [RULE_09] [RULE_10]
            default: begin
               nxt_rdata = arr_pkg::RD_UNMAPPED;                      // not ours
               nxt_hit   = 1'b0;
            end
         endcase
      end else begin
         nxt_rdata = rdata_ff;                                        // hold last answer
      end
   end

   // output registers
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rdata_ff  <= arr_pkg::RST_RDATA;
         rvalid_ff <= 1'b0;
         hit_ff    <= 1'b0;
      end else begin
         rdata_ff  <= nxt_rdata;
         rvalid_ff <= nxt_rvalid;
         hit_ff    <= nxt_hit;
      end
   end

   assign o_rdata  = rdata_ff;
   assign o_rvalid = rvalid_ff;
   assign o_hit    = hit_ff;
endmodule : arr_result_bank

// >>> arr_result_bank_monitor.sv
// checker on the ports of the result bank
`timescale 1ns/1ps
module arr_result_bank_monitor (
   input wire logic               i_mclk,               // clock
   input wire logic               i_reset_n,            // reset, active low
   input wire arr_pkg::arr_conv_s i_conv,               // conversion
   input wire logic               i_thermal_reg_flag,   // thermal level
   input wire logic               i_input_present_flag, // supply level
   input wire logic               i_batt_below_short,   // short level
   input wire arr_pkg::arr_rd_s   i_rd,                 // read request
   input wire logic [7:0]         o_rdata,              // read data
   input wire logic               o_rvalid,             // read valid
   input wire logic               o_hit                 // bank hit
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_reset_n);
   wire logic rd      = i_rd.rd;                                     // read strobe
   wire logic in_bank = (i_rd.addr >= 8'h0e) && (i_rd.addr <= 8'h12); // bank decode
   // one read, one answer, decode flag beside it
   property p_answer; rd |=> o_rvalid && (o_hit == $past(in_bank)); endproperty
   a_answer: assert property (p_answer) else $error("read answer missing");
   // no read, no strobe, data held
   property p_quiet; !rd |=> !o_rvalid && $stable(o_rdata); endproperty
   a_quiet: assert property (p_quiet) else $error("answer without read");
   property p_unmapped; rd && !in_bank |=> o_rdata == 8'h00; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped not zero");
   property p_bit7; rd && (i_rd.addr inside {8'h0f, 8'h10, 8'h12}) |=> !o_rdata[7]; endproperty
   a_bit7: assert property (p_bit7) else $error("bit 7 not zero");
   // flags pass two sync flops, so they must sit still three edges first
   property p_therm;
      $stable(i_thermal_reg_flag)[*3] ##0 (rd && i_rd.addr == 8'h0e)
         |=> o_rdata[7] == $past(i_thermal_reg_flag);
   endproperty
   a_therm: assert property (p_therm) else $error("thermal flag wrong");
   property p_vin;
      $stable(i_input_present_flag)[*3] ##0 (rd && i_rd.addr == 8'h11)
         |=> o_rdata[7] == $past(i_input_present_flag);
   endproperty
   a_vin: assert property (p_vin) else $error("supply flag wrong");
   property p_short; i_batt_below_short[*3] ##0 (rd && i_rd.addr == 8'h12) |=> o_rdata == 8'h00;
   endproperty
   a_short: assert property (p_short) else $error("current not forced");
   // conversion then read on the next edge must see the whole new code
   sequence s_batt_done; i_conv.done && i_conv.chan == arr_pkg::CH_BATT; endsequence
   sequence s_batt_read; rd && i_rd.addr == 8'h0e && !i_conv.done; endsequence
   property p_load; s_batt_done ##1 s_batt_read |=> o_rdata[6:0] == $past(i_conv.code, 2);
   endproperty
   a_load: assert property (p_load) else $error("code not loaded whole");
endmodule : arr_result_bank_monitor

// >>> arr_host_model.sv
// host model: issues register reads, collects answers
`timescale 1ns/1ps
module arr_host_model (
   input  wire logic       i_mclk,    // clock
   input  wire logic       i_reset_n, // reset, active low
   input  wire logic       i_req,     // bench asks for a read
   input  wire logic [7:0] i_addr,    // register wanted
   input  wire logic [7:0] i_rdata,   // bank data
   input  wire logic       i_rvalid,  // bank strobe
   input  wire logic       i_hit,     // bank decode
   output arr_pkg::arr_rd_s o_rd,     // request to bank
   output logic [8:0]      o_ans,     // hit and data seen
   output logic            o_got      // answer pulse
);
   // idle address is inverted each cycle, so the stale address returns on every second idle cycle
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_rd  <= '0;
         o_ans <= 9'h000;
         o_got <= 1'b0;
      end else begin
         o_rd.rd   <= i_req;                       // reads only, no writes relied on
         o_rd.addr <= i_req ? i_addr : ~o_rd.addr; // address held for the strobe cycle
         o_got     <= i_rvalid;                    // take answer at its edge
         if (i_rvalid) o_ans <= {i_hit, i_rdata};
      end
   end
endmodule : arr_host_model

// >>> arr_tb_top.sv
// self-checking bench for the result bank
`timescale 1ns/1ps
module tb_top;
   logic               i_mclk = 1'b0;    // clock
   logic               i_reset_n = 1'b0; // reset
   arr_pkg::arr_conv_s conv = '0;        // conversion drive
   logic               therm = 1'b0, vin = 1'b0, shrt = 1'b0, wr = 1'b0, req = 1'b0;
   logic [7:0]         addr = 8'h00, wdata = 8'h00;
   arr_pkg::arr_rd_s   rd;               // host request
   logic [7:0]         rdata;            // bank answer
   logic               rvalid, hit, got; // strobes
   logic [8:0]         ans;              // captured answer
   int                 err_total = 0, num_checks = 0, cycles = 0;
   always #5 i_mclk = ~i_mclk;
   arr_result_bank dut_u (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_conv(conv),
      .i_thermal_reg_flag(therm), .i_input_present_flag(vin), .i_batt_below_short(shrt),
      .i_rd(rd), .i_wr(wr), .i_wdata(wdata), .o_rdata(rdata), .o_rvalid(rvalid), .o_hit(hit));
   arr_host_model host_u (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_req(req), .i_addr(addr),
      .i_rdata(rdata), .i_rvalid(rvalid), .i_hit(hit), .o_rd(rd), .o_ans(ans), .o_got(got));
   task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // optional conversion launched with the request, so the read lands one edge later
   task automatic xfer(input logic cv, input int ch, input logic [6:0] cd,
                       input logic [7:0] a, input logic [7:0] exp);
      @(posedge i_mclk) #1;
      conv = '{done: cv, chan: arr_pkg::arr_chan_e'(ch), code: cd};
      req  = 1'b1;
      addr = a;
      @(posedge i_mclk) #1;
      conv.done = 1'b0;
      req       = 1'b0;
      for (int i = 0; i < 8 && got !== 1'b1; i++) @(posedge i_mclk) #1;
      chk(ans, {(a >= 8'h0e && a <= 8'h12), exp});
   endtask : xfer
   task automatic settle();
      repeat (3) @(posedge i_mclk); // two sync flops plus margin
   endtask : settle
   task automatic t_reset(); // every code reads offset value
      for (int a = 8'h0e; a <= 8'h12; a++) xfer(0, 0, 7'h00, 8'(a), 8'h00);
   endtask : t_reset
   task automatic t_codes(); // full scale with flags set, mid pattern with flags clear
      for (int p = 0; p < 2; p++) begin
         therm = (p == 0);
         vin   = (p == 0);
         settle();
         for (int c = 0; c < 5; c++) xfer(1, c, p ? 7'h55 : 7'h7f, 8'(8'h0e + c),
            {(p == 0) && (c == 0 || c == 3), p ? 7'h55 : 7'h7f});
      end
   endtask : t_codes
   task automatic t_short(); // stored while short and read while short both give zero
      shrt = 1'b1;
      settle();
      xfer(1, 4, 7'h55, 8'h12, 8'h00);
      shrt = 1'b0;
      settle();
      xfer(0, 4, 7'h00, 8'h12, 8'h00);
      xfer(1, 4, 7'h2a, 8'h12, 8'h2a);
      shrt = 1'b1;
      settle();
      xfer(0, 4, 7'h00, 8'h12, 8'h00);
      shrt = 1'b0;
   endtask : t_short
   task automatic t_write(); // writes change nothing, outside addresses answer zero
      @(posedge i_mclk) #1;
      wr    = 1'b1;
      wdata = 8'hff;
      @(posedge i_mclk) #1;
      wr = 1'b0;
      xfer(0, 0, 7'h00, 8'h0e, 8'h55);
      xfer(0, 0, 7'h00, 8'h0d, 8'h00);
      xfer(0, 0, 7'h00, 8'h13, 8'h00);
   endtask : t_write
   task automatic close_out();
      $display("checks=%0d errors=%0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : close_out
   // cut a hang short
   always @(posedge i_mclk) begin
      cycles++;
      if (cycles == 3000) begin
         err_total++;
         close_out();
      end
   end
   initial begin
      repeat (2) @(posedge i_mclk);
      #1 i_reset_n = 1'b1;
      t_reset();
      t_codes();
      t_short();
      t_write();
      i_reset_n = 1'b0; // second reset in mid-run
      @(posedge i_mclk) #1 i_reset_n = 1'b1;
      t_reset();
      close_out();
   end
endmodule : tb_top
bind arr_result_bank arr_result_bank_monitor mon_u (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
   .i_conv(i_conv), .i_thermal_reg_flag(i_thermal_reg_flag), .i_rd(i_rd), .o_hit(o_hit),
   .i_input_present_flag(i_input_present_flag), .i_batt_below_short(i_batt_below_short),
   .o_rdata(o_rdata), .o_rvalid(o_rvalid));
